// ### hdl/gcn_port.sv
// GPIO port with change notification behind an AXI4-Lite slave
// Notes on behaviour
// - Direction bit 1 makes the pin an input; 0 drives it as output.
// - Every reset sets all direction bits, so all pins start as inputs.
// - Output latch reads return latch contents; writes update the latch.
// - Pin-level reads return sampled pins; writes to it go to the latch.
// - Open-drain pins only drive low and float instead of driving high.
// - Analog select resets to all ones, so pins start analog.
// - Pin-level reads show zero for every pin configured as analog.
// - An output pin with analog select set still drives its latch level.
// - Change detection samples pins on clk, runs only while the change control on bit is set, and raises a request.
// - Per-pin change enable; only enabled pins feed the change request.
// - Change status flags a change since last pin-level read; that read rearms.
// - Independent weak pull-up and pull-down enable bits per pin.
// - Set, clear and invert aliases change only bits written as one.
// - Alias reads return nothing useful; base register shows the effect.
`timescale 1ns/1ps
module gcn_port #(
    parameter int N = 16
) (
    input  wire logic                          clk,
    input  wire logic                          rstn,
    input  wire logic [gcn_pkg::GCN_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [gcn_pkg::GCN_DATA_W-1:0] s_axi_wdata,
    input  wire logic [gcn_pkg::GCN_STRB_W-1:0] s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [gcn_pkg::GCN_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [gcn_pkg::GCN_DATA_W-1:0]     s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic [N-1:0]                  pin_in,
    output logic [N-1:0]                       pin_out,
    output logic [N-1:0]                       pin_oe,
    output logic [N-1:0]                       pullup_en,
    output logic [N-1:0]                       pulldown_en,
    output logic [N-1:0]                       analog_en,
    output logic                               change_irq
);
    import gcn_pkg::*;
    logic                  rst_meta_reg;
    logic                  rst_q;
    logic [N-1:0]          pin_meta_reg;
    logic [N-1:0]          pin_sync_reg;
    logic [N-1:0]          regs_reg  [GCN_NUM_REGS];
    logic [N-1:0]          regs_next [GCN_NUM_REGS];
    logic [N-1:0]          change;
    logic [N-1:0]          strb_mask;
    logic [N-1:0]          pad_out_reg;
    logic [N-1:0]          pad_out_next;
    logic [N-1:0]          pad_oe_reg;
    logic [N-1:0]          pad_oe_next;
    logic                  irq_reg;
    logic                  irq_next;
    logic [GCN_ADDR_W-1:0] aw_addr_reg;
    logic [GCN_ADDR_W-1:0] aw_addr_next;
    logic [N-1:0]          w_data_reg;
    logic [N-1:0]          w_data_next;
    logic [N-1:0]          w_mask_reg;
    logic [N-1:0]          w_mask_next;
    logic                  have_aw_reg;
    logic                  have_aw_next;
    logic                  have_w_reg;
    logic                  have_w_next;
    logic                  awready_reg;
    logic                  awready_next;
    logic                  wready_reg;
    logic                  wready_next;
    logic                  bvalid_reg;
    logic                  bvalid_next;
    logic [1:0]            bresp_reg;
    logic [1:0]            bresp_next;
    logic                  arready_reg;
    logic                  arready_next;
    logic                  rvalid_reg;
    logic                  rvalid_next;
    logic [1:0]            rresp_reg;
    logic [1:0]            rresp_next;
    logic [GCN_DATA_W-1:0] rdata_reg;
    logic [GCN_DATA_W-1:0] rdata_next;
    logic                  wr_do;
    logic                  rd_take;
    logic [GCN_IDX_W-1:0]  wr_idx;
    logic [1:0]            wr_op;
    logic [GCN_IDX_W-1:0]  rd_idx;
    logic [1:0]            rd_op;
    logic [GCN_IDX_W-1:0]  wr_tgt;
    logic                  rd_port_base;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta_reg <= GCN_RST_ZERO;
            rst_q        <= GCN_RST_ZERO;
        end
        else
        begin
            rst_meta_reg <= GCN_RST_ONE;
            rst_q        <= rst_meta_reg;
        end
    end

    // Pin synchroniser; only pin_sync_reg is read by logic
    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end
        else
        begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Byte strobes widened to per-bit mask
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++)
        begin : g_mask
            assign strb_mask[gi] = s_axi_wstrb[gi / 8];
        end
    endgenerate

    function automatic logic [N-1:0] alias_apply(input logic [N-1:0] base, input logic [N-1:0] d,
                                                  input logic [N-1:0] m, input logic [1:0] op);
        logic [N-1:0] dm;
        dm = d & m;
        unique case (op)
            GCN_OP_BASE: alias_apply = (base & ~m) | dm;
            GCN_OP_CLR:  alias_apply = base & ~dm;
            GCN_OP_SET:  alias_apply = base | dm;
            GCN_OP_INV:  alias_apply = base ^ dm;
        endcase
    endfunction

    assign wr_idx       = aw_addr_reg[GCN_IDX_LSB +: GCN_IDX_W];
    assign wr_op        = aw_addr_reg[GCN_OP_LSB +: 2];
    assign rd_idx       = s_axi_araddr[GCN_IDX_LSB +: GCN_IDX_W];
    assign rd_op        = s_axi_araddr[GCN_OP_LSB +: 2];
    assign wr_do        = have_aw_reg & have_w_reg & ~bvalid_reg;
    assign rd_take      = s_axi_arvalid & arready_reg;
    assign rd_port_base = rd_take & (rd_idx == GCN_IDX_PORT) & (rd_op == GCN_OP_BASE);
    assign wr_tgt       = (wr_idx == GCN_IDX_PORT) ? GCN_IDX_LAT : wr_idx;

    // Write channel handshake, address and data in either order
    always_comb
    begin
        aw_addr_next = aw_addr_reg;
        w_data_next  = w_data_reg;
        w_mask_next  = w_mask_reg;
        have_aw_next = have_aw_reg;
        have_w_next  = have_w_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        if (s_axi_awvalid && awready_reg)
        begin
            aw_addr_next = s_axi_awaddr;
            have_aw_next = 1'b1;
        end
        if (s_axi_wvalid && wready_reg)
        begin
            w_data_next = s_axi_wdata[N-1:0];
            w_mask_next = strb_mask;
            have_w_next = 1'b1;
        end
        if (wr_do)
        begin
            have_aw_next = 1'b0;
            have_w_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = (wr_idx < GCN_IDX_W'(GCN_NUM_REGS)) ? GCN_RESP_OKAY : GCN_RESP_SLVERR;
        end
        else if (bvalid_reg && s_axi_bready)
        begin
            bvalid_next = 1'b0;
        end
        awready_next = ~have_aw_next & ~bvalid_next;
        wready_next  = ~have_w_next & ~bvalid_next;
    end

    // Read channel: one request at a time, answer one cycle later
    always_comb
    begin
        arready_next = arready_reg;
        rvalid_next  = rvalid_reg;
        rresp_next   = rresp_reg;
        rdata_next   = rdata_reg;
        if (rd_take)
        begin
            arready_next = 1'b0;
            rvalid_next  = 1'b1;
            rdata_next   = '0;
            rresp_next   = GCN_RESP_OKAY;
            if (rd_idx >= GCN_IDX_W'(GCN_NUM_REGS))
                rresp_next = GCN_RESP_SLVERR;
            else if (rd_op != GCN_OP_BASE)
                rdata_next = '0;
            else if (rd_idx == GCN_IDX_PORT)
                rdata_next[N-1:0] = pin_sync_reg & ~regs_reg[GCN_IDX_ANALOG_SELECT_BIT];
            else
                rdata_next[N-1:0] = regs_reg[rd_idx];
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_next  = 1'b0;
            arready_next = 1'b1;
        end
    end

    // Register file, aliases and change detection
    always_comb
    begin
        regs_next = regs_reg;
        if (wr_do && wr_tgt < GCN_IDX_W'(GCN_NUM_REGS) && wr_tgt != GCN_IDX_CNSTAT)
            regs_next[wr_tgt] = alias_apply(regs_reg[wr_tgt], w_data_reg, w_mask_reg, wr_op);
        if (rd_port_base)
        begin
            regs_next[GCN_IDX_PORT]   = pin_sync_reg;
            regs_next[GCN_IDX_CNSTAT] = '0;
        end
        // Against the new snapshot, so a change already returned by the read does not stick
        change = (pin_sync_reg ^ regs_next[GCN_IDX_PORT]) & regs_reg[GCN_IDX_CNEN]
                 & {N{regs_reg[GCN_IDX_CNCON][GCN_ON_BIT]}};
        regs_next[GCN_IDX_CNSTAT] = regs_next[GCN_IDX_CNSTAT] | change;
        pad_oe_next  = ~regs_reg[GCN_IDX_DIR] & ~(regs_reg[GCN_IDX_ODC] & regs_reg[GCN_IDX_LAT]);
        pad_out_next = regs_reg[GCN_IDX_LAT] & ~regs_reg[GCN_IDX_ODC];
        irq_next     = |(regs_reg[GCN_IDX_CNSTAT] & regs_reg[GCN_IDX_CNEN]);
    end

    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            for (int i = 0; i < GCN_NUM_REGS; i++)
                regs_reg[i] <= '0;
            regs_reg[GCN_IDX_DIR]   <= {N{GCN_RST_ONE}};
            regs_reg[GCN_IDX_ANALOG_SELECT_BIT] <= {N{GCN_RST_ONE}};
            pad_out_reg  <= '0;
            pad_oe_reg   <= '0;
            irq_reg      <= 1'b0;
            aw_addr_reg  <= '0;
            w_data_reg   <= '0;
            w_mask_reg   <= '0;
            have_aw_reg  <= 1'b0;
            have_w_reg   <= 1'b0;
            awready_reg  <= 1'b1;
            wready_reg   <= 1'b1;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= GCN_RESP_OKAY;
            arready_reg  <= 1'b1;
            rvalid_reg   <= 1'b0;
            rresp_reg    <= GCN_RESP_OKAY;
            rdata_reg    <= '0;
        end
        else
        begin
            regs_reg     <= regs_next;
            pad_out_reg  <= pad_out_next;
            pad_oe_reg   <= pad_oe_next;
            irq_reg      <= irq_next;
            aw_addr_reg  <= aw_addr_next;
            w_data_reg   <= w_data_next;
            w_mask_reg   <= w_mask_next;
            have_aw_reg  <= have_aw_next;
            have_w_reg   <= have_w_next;
            awready_reg  <= awready_next;
            wready_reg   <= wready_next;
            bvalid_reg   <= bvalid_next;
            bresp_reg    <= bresp_next;
            arready_reg  <= arready_next;
            rvalid_reg   <= rvalid_next;
            rresp_reg    <= rresp_next;
            rdata_reg    <= rdata_next;
        end
    end
    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    assign pin_out       = pad_out_reg;
    assign pin_oe        = pad_oe_reg;
    assign pullup_en     = regs_reg[GCN_IDX_PU];
    assign pulldown_en   = regs_reg[GCN_IDX_PD];
    assign analog_en     = regs_reg[GCN_IDX_ANALOG_SELECT_BIT];
    assign change_irq    = irq_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_q);

    sequence port_read_s;
        rd_port_base ##0 (change == '0);
    endsequence
    sequence latch_set_s;
        wr_do && wr_tgt == GCN_IDX_LAT && wr_op == GCN_OP_SET;
    endsequence

    dir_reset_a: assert property ($rose(rst_q) |-> regs_reg[GCN_IDX_DIR] == {N{GCN_RST_ONE}})
        else $error("direction not all inputs after reset");
    analog_select_bit_reset_a: assert property ($rose(rst_q) |-> regs_reg[GCN_IDX_ANALOG_SELECT_BIT] == {N{GCN_RST_ONE}})
        else $error("analog select not all ones after reset");
    pad_drive_a: assert property ((pad_oe_reg & $past(regs_reg[GCN_IDX_DIR])) == '0)
        else $error("input pin driven");
    output_drive_a: assert property (((~$past(regs_reg[GCN_IDX_DIR]) & ~$past(regs_reg[GCN_IDX_ODC])) & ~pad_oe_reg) == '0)
        else $error("push-pull output not driven");
    open_drain_a: assert property ((pad_out_reg & $past(regs_reg[GCN_IDX_ODC])) == '0)
        else $error("open-drain pin driven high");
    analog_zero_a: assert property (rd_port_base |=> (rdata_reg[N-1:0] & $past(regs_reg[GCN_IDX_ANALOG_SELECT_BIT])) == '0)
        else $error("analog pin read nonzero");
    status_rearm_a: assert property (port_read_s |=> regs_reg[GCN_IDX_CNSTAT] == '0 ##1 1'b1)
        else $error("pin-level read did not rearm change status");
    change_irq_a: assert property (change_irq == |$past(regs_reg[GCN_IDX_CNSTAT] & regs_reg[GCN_IDX_CNEN]))
        else $error("change request wrong");
    latch_set_a: assert property (latch_set_s |=> regs_reg[GCN_IDX_LAT]
                 == ($past(regs_reg[GCN_IDX_LAT]) | ($past(w_data_reg) & $past(w_mask_reg))))
        else $error("latch set alias wrong");
    alias_read_a: assert property (rd_take && rd_op != GCN_OP_BASE |=> rvalid_reg && rdata_reg == '0)
        else $error("alias read nonzero");
endmodule

// ### hdl/gcn_pkg.sv
// Constants for the GPIO port with change notification
package gcn_pkg;
    localparam int          GCN_ADDR_W     = 8;
    localparam int          GCN_DATA_W     = 32;
    localparam int          GCN_STRB_W     = 4;
    localparam int          GCN_NUM_REGS   = 10;
    localparam int          GCN_OP_LSB     = 2;
    localparam int          GCN_IDX_LSB    = 4;
    localparam int          GCN_IDX_W      = 4;
    localparam int          GCN_ON_BIT     = 15;
    // Register index; byte address is index times 16 plus alias op times 4
    localparam logic [3:0]  GCN_IDX_DIR    = 4'h0;
    localparam logic [3:0]  GCN_IDX_LAT    = 4'h1;
    localparam logic [3:0]  GCN_IDX_PORT   = 4'h2;
    localparam logic [3:0]  GCN_IDX_ODC    = 4'h3;
    localparam logic [3:0]  GCN_IDX_ANALOG_SELECT_BIT  = 4'h4;
    localparam logic [3:0]  GCN_IDX_CNEN   = 4'h5;
    localparam logic [3:0]  GCN_IDX_CNSTAT = 4'h6;
    localparam logic [3:0]  GCN_IDX_PU     = 4'h7;
    localparam logic [3:0]  GCN_IDX_PD     = 4'h8;
    localparam logic [3:0]  GCN_IDX_CNCON  = 4'h9;
    // Alias selector within a register slot
    localparam logic [1:0]  GCN_OP_BASE    = 2'h0;
    localparam logic [1:0]  GCN_OP_CLR     = 2'h1;
    localparam logic [1:0]  GCN_OP_SET     = 2'h2;
    localparam logic [1:0]  GCN_OP_INV     = 2'h3;
    localparam logic [1:0]  GCN_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  GCN_RESP_SLVERR = 2'h2;
    // Reset fill bits: all inputs, all analog, everything else off
    localparam logic        GCN_RST_ONE    = 1'b1;
    localparam logic        GCN_RST_ZERO   = 1'b0;
endpackage

// ### sim/gcn_board.sv
// Board-side model of the circuitry hanging on the port pins
`timescale 1ns/1ps
module gcn_board #(
    parameter int N = 16
) (
    input  wire logic         clk,
    input  wire logic [N-1:0] pin_out,
    input  wire logic [N-1:0] pin_oe,
    input  wire logic [N-1:0] pullup_en,
    input  wire logic [N-1:0] pulldown_en,
    input  wire logic [N-1:0] ext_val,
    input  wire logic [N-1:0] ext_en,
    output logic [N-1:0]      pin_in
);
    logic [N-1:0] churn = '0;

    // Undriven, unpulled pins wander every cycle so a stale level never passes
    always_ff @(posedge clk)
        churn <= ~churn;

    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pullup_en[i])
                pin_in[i] = 1'b1;
            else if (pulldown_en[i])
                pin_in[i] = 1'b0;
            else
                pin_in[i] = churn[i];
        end
    end
endmodule

// ### sim/test_gcn_port.sv
// Self-checking testbench for the GPIO port with change notification
`timescale 1ns/1ps
module test_gcn_port;
    import gcn_pkg::*;
    typedef struct packed {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} gcn_row_t;
    logic        clk = 1'b0, rstn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_val;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, change_irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] pin_in, pin_out, pin_oe, pullup_en, pulldown_en, analog_en;
    logic [15:0] ext_val = 16'hFFFF, ext_en = 16'hFFFF;
    int          err_total = 0, check_count = 0, cycles = 0;
    gcn_row_t    rows [10] = '{
        '{8'h10, 32'h0000_1234, 8'h10, 32'h0000_1234}, '{8'h20, 32'h0000_A5A5, 8'h10, 32'h0000_A5A5},
        '{8'h18, 32'h0000_000F, 8'h10, 32'h0000_A5AF}, '{8'h14, 32'h0000_00A0, 8'h10, 32'h0000_A50F},
        '{8'h1C, 32'h0000_FFFF, 8'h10, 32'h0000_5AF0}, '{8'h70, 32'h0000_00FF, 8'h70, 32'h0000_00FF},
        '{8'h80, 32'h0000_FF00, 8'h80, 32'h0000_FF00}, '{8'h38, 32'h0000_0F0F, 8'h30, 32'h0000_0F0F},
        '{8'h58, 32'h0000_0003, 8'h58, 32'h0000_0000}, '{8'h0C, 32'h0000_00F0, 8'h00, 32'h0000_FF0F}};

    gcn_port #(.N(16)) dut (.clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en), .pulldown_en(pulldown_en),
        .analog_en(analog_en), .change_irq(change_irq));
    gcn_board #(.N(16)) board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
        .pulldown_en(pulldown_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

    always #12.5 clk = ~clk;

    task automatic results();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_total++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int   n = 0;
        logic aw_done = 1'b0, w_done = 1'b0, b_done = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_done && n < 100)
        begin
            @(posedge clk);
            n++;
            if (!aw_done && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (!w_done && s_axi_wready) s_axi_wvalid <= 1'b0;
            aw_done = aw_done | s_axi_awready;
            w_done = w_done | s_axi_wready;
            b_done = s_axi_bvalid;
        end
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
        if (!b_done) err_total++;
    endtask

    task automatic rd(input logic [7:0] a);
        int   n = 0;
        logic ar_done = 1'b0, r_done = 1'b0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_done && n < 100)
        begin
            @(posedge clk);
            n++;
            if (!ar_done && s_axi_arready) s_axi_arvalid <= 1'b0;
            ar_done = ar_done | s_axi_arready;
            r_done = s_axi_rvalid;
        end
        s_axi_rready <= 1'b0;
        rd_val = s_axi_rdata;
        resp = s_axi_rresp;
        if (!r_done) err_total++;
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (rows[i])
        begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra);
            chk("row readback", rd_val, rows[i].ex);
        end
        chk("pullup_en", {16'h0, pullup_en}, 32'h0000_00FF);
        chk("pulldown_en", {16'h0, pulldown_en}, 32'h0000_FF00);
        wr(8'hA0, 32'h0000_FFFF);
        chk("unmapped bresp", {30'h0, resp}, {30'h0, GCN_RESP_SLVERR});
        rd(8'hA0);
        chk("unmapped rresp", {30'h0, resp}, {30'h0, GCN_RESP_SLVERR});
        // Second reset in mid-run
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        chk("pin_oe after reset", {16'h0, pin_oe}, 32'h0);
        chk("analog_en after reset", {16'h0, analog_en}, 32'h0000_FFFF);
        rd(8'h00);
        chk("direction reset", rd_val, 32'h0000_FFFF);
        rd(8'h40);
        chk("analog reset", rd_val, 32'h0000_FFFF);
        wr(8'h44, 32'h0000_00FF);
        wr(8'h10, 32'h0000_0105);
        wr(8'h04, 32'h0000_010F);
        repeat (4) @(posedge clk);
        chk("pin_oe outputs", {16'h0, pin_oe}, 32'h0000_010F);
        chk("pin_out outputs", {16'h0, pin_out}, 32'h0000_0105);
        wr(8'h38, 32'h0000_0003);
        repeat (4) @(posedge clk);
        chk("pin_oe open drain", {16'h0, pin_oe}, 32'h0000_010E);
        chk("pin_out open drain", {16'h0, pin_out & 16'h000F}, 32'h0000_0004);
        rd(8'h20);
        chk("pin level", rd_val, 32'h0000_00F5);
        wr(8'h08, 32'h0000_0100);
        repeat (4) @(posedge clk);
        chk("pin_oe analog input", {16'h0, pin_oe}, 32'h0000_000E);
        wr(8'h90, 32'h0000_8000);
        wr(8'h50, 32'h0000_0030);
        rd(8'h20);
        @(posedge clk);
        ext_val <= 16'hFFAF;
        repeat (6) @(posedge clk);
        chk("change_irq raised", {31'h0, change_irq}, 32'h1);
        rd(8'h60);
        chk("change status", rd_val, 32'h0000_0010);
        rd(8'h20);
        chk("pin level after change", rd_val, 32'h0000_00A5);
        repeat (3) @(posedge clk);
        chk("change_irq cleared", {31'h0, change_irq}, 32'h0);
        rd(8'h60);
        chk("change status rearmed", rd_val, 32'h0);
        wr(8'h78, 32'h0000_0080);
        @(posedge clk);
        ext_en <= 16'hFF7F;
        repeat (4) @(posedge clk);
        rd(8'h20);
        chk("pulled-up pin", rd_val, 32'h0000_00A5);
        wr(8'h74, 32'h0000_0080);
        wr(8'h88, 32'h0000_0080);
        repeat (4) @(posedge clk);
        rd(8'h20);
        chk("pulled-down pin", rd_val, 32'h0000_0025);
        results();
    end
endmodule
